// >>> dir_pkg.sv
// Constants, field layouts and types shared by the readback slave.
// Assumes a single core clock much faster than the serial clock.
package dir_pkg;

  localparam int        CLK_HZ          = 25_000_000;
  localparam logic [4:0] ADDR_FIXED     = 5'h13;
  localparam int        ADDR_FIX_MSB    = 7;
  localparam int        ADDR_FIX_LSB    = 3;
  localparam int        ADDR_PIN_HI_POS = 2;
  localparam int        ADDR_PIN_LO_POS = 1;
  localparam int        RW_POS          = 0;
  localparam int        CTL_EXT_HI_POS  = 7;
  localparam int        CTL_EXT_LO_POS  = 6;
  localparam int        CTL_SEL_MSB     = 2;
  localparam int        CTL_SEL_LSB     = 1;
  localparam int        CTL_PD_POS      = 0;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [5:0] PD_FILL        = 6'h3F;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam int        NUM_CH          = 4;
  localparam int        CH_W            = 18;
  localparam logic [17:0] CH_RESET      = 18'h00000;
  localparam logic [1:0] IDX_LAST_PD    = 2'h2;
  localparam logic [1:0] IDX_LAST_NOPD  = 2'h1;
  localparam int        FIFO_DEPTH      = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CTRL, ST_ACK_CTRL, ST_TX, ST_TX_ACK
  } dir_state_e;

  typedef struct packed {
    logic [1:0]      ch;
    logic [CH_W-1:0] word;
  } dir_wr_s;

endpackage : dir_pkg

// >>> dir_slave.sv
// Two-wire readback slave of a four channel converter, channel storage included.
// Assumes serial clock well below a quarter of the core clock; pins are asynchronous.
`timescale 1ns/100ps

// How it works
// - A transaction opens with our address and a cleared direction bit, which we acknowledge.
// - The control byte that follows the write address is stored and acknowledged.
// - After a repeated start the same address with the direction bit set is acknowledged.
// - The address matches when its top five bits are 10011, then both address pins, then direction.
// - The channel select field of the last control byte picks the channel returned.
// - With the power-down flag clear exactly the high then the low data byte are sent.
// - With the power-down flag set a power-down byte, then high, then low byte are sent.
// - The power-down byte carries the two stored mode bits on top and ones below.
// - The data word goes out high byte first, every byte MSB first.
// - Each channel holds 18 bits, two mode bits above a 16-bit code, read back from storage.
module dir_slave (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  input  wire logic          i_addr_pin_hi,
  input  wire logic          i_addr_pin_lo,
  output logic               o_sda_out,
  output logic               o_sda_oe_n,
  input  wire logic          i_wr_valid,
  input  wire dir_pkg::dir_wr_s i_wr_data,
  output logic               o_wr_ready,
  output logic [7:0]         o_ctrl_byte,
  output logic               o_busy,
  output logic [dir_pkg::NUM_CH-1:0][dir_pkg::CH_W-1:0] o_chan_regs
);
  import dir_pkg::*;

  typedef struct packed {
    logic                        scl_s1;
    logic                        scl_s2;
    logic                        scl_p;
    logic                        sda_s1;
    logic                        sda_s2;
    logic                        sda_p;
    logic                        ahi_s1;
    logic                        ahi_s2;
    logic                        alo_s1;
    logic                        alo_s2;
    dir_state_e                  state;
    logic [3:0]                  bit_cnt;
    logic [7:0]                  shreg;
    logic [7:0]                  cur_byte;
    logic                        rw;
    logic                        mack;
    logic [7:0]                  ctrl;
    logic [CH_W-1:0]             snap;
    logic [1:0]                  byte_idx;
    logic                        drv;
    logic [NUM_CH-1:0][CH_W-1:0] chan;
    logic [FIFO_DEPTH-1:0][$bits(dir_wr_s)-1:0] fbuf;
    logic                        wp;
    logic                        rp;
    logic [1:0]                  fcnt;
  } dir_st_s;

  dir_st_s s_q;
  dir_st_s s_d;

  // Byte to send for a given position in the read reply
  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic pd,
                                         input logic [CH_W-1:0] w);
    logic [7:0] b;
    b = w[7:0];
    if (pd) begin
      case (idx)
        2'h0:    b = {w[17:16], PD_FILL};
        2'h1:    b = w[15:8];
        default: b = w[7:0];
      endcase
    end else if (idx == 2'h0) begin
      b = w[15:8];
    end
    return b;
  endfunction : tx_byte

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       addr_match;
  logic       pd_flag;
  logic [1:0] sel;
  logic [1:0] idx_last;
  logic       push;
  logic       pop;
  logic [7:0] nb;
  dir_wr_s    head;

  assign scl_rise   = s_q.scl_s2 & ~s_q.scl_p;
  assign scl_fall   = ~s_q.scl_s2 & s_q.scl_p;
  assign start_c    = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_s2 & s_q.sda_p;
  assign stop_c     = s_q.scl_s2 & s_q.scl_p & s_q.sda_s2 & ~s_q.sda_p;
  assign addr_match = (s_q.shreg[ADDR_FIX_MSB:ADDR_FIX_LSB] == ADDR_FIXED)
                    && (s_q.shreg[ADDR_PIN_HI_POS] == s_q.ahi_s2)
                    && (s_q.shreg[ADDR_PIN_LO_POS] == s_q.alo_s2);
  assign pd_flag    = s_q.ctrl[CTL_PD_POS];
  assign sel        = s_q.ctrl[CTL_SEL_MSB:CTL_SEL_LSB];
  assign idx_last   = pd_flag ? IDX_LAST_PD : IDX_LAST_NOPD;
  assign o_wr_ready = (s_q.fcnt != 2'(FIFO_DEPTH));
  assign push       = i_wr_valid & o_wr_ready;
  // Storage updates wait while any frame holds the slave busy
  assign pop        = (s_q.fcnt != 2'h0) && (s_q.state == ST_IDLE);
  assign head       = dir_wr_s'(s_q.fbuf[s_q.rp]);

  always_comb begin
    s_d        = s_q;
    nb         = 8'h00;
    s_d.scl_s1 = i_scl;
    s_d.scl_s2 = s_q.scl_s1;
    s_d.scl_p  = s_q.scl_s2;
    s_d.sda_s1 = i_sda;
    s_d.sda_s2 = s_q.sda_s1;
    s_d.sda_p  = s_q.sda_s2;
    s_d.ahi_s1 = i_addr_pin_hi;
    s_d.ahi_s2 = s_q.ahi_s1;
    s_d.alo_s1 = i_addr_pin_lo;
    s_d.alo_s2 = s_q.alo_s1;

    if (push) begin
      s_d.fbuf[s_q.wp] = i_wr_data;
      s_d.wp           = ~s_q.wp;
    end
    if (pop) begin
      s_d.chan[head.ch] = head.word;
      s_d.rp            = ~s_q.rp;
    end
    s_d.fcnt = s_q.fcnt + 2'(push) - 2'(pop);

    if (start_c) begin
      s_d.state   = ST_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.drv     = 1'b0;
    end else if (stop_c) begin
      s_d.state = ST_IDLE;
      s_d.drv   = 1'b0;
    end else begin
      case (s_q.state)
        ST_IDLE: begin
          s_d.drv = 1'b0;
        end
        ST_ADDR, ST_CTRL: begin
          if (scl_rise && s_q.bit_cnt != BYTE_BITS) begin
            s_d.shreg   = {s_q.shreg[6:0], s_q.sda_s2};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (scl_fall && s_q.bit_cnt == BYTE_BITS) begin
            if (s_q.state == ST_CTRL) begin
              s_d.ctrl  = s_q.shreg;
              s_d.drv   = 1'b1;
              s_d.state = ST_ACK_CTRL;
            end else if (addr_match) begin
              s_d.rw    = s_q.shreg[RW_POS];
              s_d.drv   = 1'b1;
              s_d.state = ST_ACK_ADDR;
            end else begin
              s_d.state = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            s_d.bit_cnt = 4'h0;
            if (s_q.rw) begin
              s_d.snap     = s_q.chan[sel];
              nb           = tx_byte(2'h0, pd_flag, s_q.chan[sel]);
              s_d.cur_byte = nb;
              s_d.drv      = ~nb[7];
              s_d.shreg    = {nb[6:0], 1'b1};
              s_d.bit_cnt  = 4'h1;
              s_d.byte_idx = 2'h0;
              s_d.state    = ST_TX;
            end else begin
              s_d.drv   = 1'b0;
              s_d.state = ST_CTRL;
            end
          end
        end
        ST_ACK_CTRL: begin
          // Further bytes in this frame are not ours to take
          if (scl_fall) begin
            s_d.drv   = 1'b0;
            s_d.state = ST_IDLE;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (s_q.bit_cnt == BYTE_BITS) begin
              s_d.drv   = 1'b0;
              s_d.state = ST_TX_ACK;
            end else begin
              s_d.drv     = ~s_q.shreg[7];
              s_d.shreg   = {s_q.shreg[6:0], 1'b1};
              s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            s_d.mack = ~s_q.sda_s2;
          end else if (scl_fall) begin
            if (s_q.mack && s_q.byte_idx != idx_last) begin
              nb           = tx_byte(s_q.byte_idx + 2'h1, pd_flag, s_q.snap);
              s_d.cur_byte = nb;
              s_d.byte_idx = s_q.byte_idx + 2'h1;
              s_d.drv      = ~nb[7];
              s_d.shreg    = {nb[6:0], 1'b1};
              s_d.bit_cnt  = 4'h1;
              s_d.state    = ST_TX;
            end else begin
              // Refusal or a reply past its end: let the line go
              s_d.state = ST_IDLE;
            end
          end
        end
        default: begin
          s_d.state = ST_IDLE;
          s_d.drv   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q        <= '0;
      // Idle bus level, so no false edge follows reset
      s_q.scl_s1 <= 1'b1;
      s_q.scl_s2 <= 1'b1;
      s_q.scl_p  <= 1'b1;
      s_q.sda_s1 <= 1'b1;
      s_q.sda_s2 <= 1'b1;
      s_q.sda_p  <= 1'b1;
      s_q.state <= ST_IDLE;
      s_q.ctrl  <= CTRL_RESET;
      s_q.chan  <= {NUM_CH{CH_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sda_out   = 1'b0;
  assign o_sda_oe_n  = ~s_q.drv;
  assign o_ctrl_byte = s_q.ctrl;
  assign o_busy      = (s_q.state != ST_IDLE);
  assign o_chan_regs = s_q.chan;

  property p_ack_addr;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_ADDR && scl_fall && s_q.bit_cnt == BYTE_BITS && addr_match
     && !start_c && !stop_c) |=> (!o_sda_oe_n && s_q.state == ST_ACK_ADDR);
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

  property p_ack_ctrl;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_CTRL && scl_fall && s_q.bit_cnt == BYTE_BITS && !start_c && !stop_c)
      |=> (!o_sda_oe_n && o_ctrl_byte == $past(s_q.shreg));
  endproperty
  a_ack_ctrl: assert property (p_ack_ctrl) else $error("control byte lost");

  property p_read_addr;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_ACK_ADDR && s_q.rw && scl_fall && !start_c && !stop_c)
      |=> (s_q.state == ST_TX && s_q.bit_cnt == 4'h1);
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address not served");

  property p_no_match;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_ADDR && scl_fall && s_q.bit_cnt == BYTE_BITS && !addr_match
     && !start_c && !stop_c) |=> (o_sda_oe_n && s_q.state == ST_IDLE);
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign address acknowledged");

  property p_select;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_ACK_ADDR && s_q.rw && scl_fall && !start_c && !stop_c)
      |=> (s_q.snap == $past(s_q.chan[sel]));
  endproperty
  a_select: assert property (p_select) else $error("wrong channel captured");

  property p_byte_count;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_TX_ACK && scl_fall && s_q.mack && !start_c && !stop_c)
      |=> (s_q.state == ST_IDLE) == ($past(s_q.byte_idx) == (pd_flag ? 2'h2 : 2'h1));
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("reply length wrong");

  property p_pd_byte;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_TX && s_q.byte_idx == 2'h0 && pd_flag)
      |-> (s_q.cur_byte == {s_q.snap[17:16], PD_FILL});
  endproperty
  a_pd_byte: assert property (p_pd_byte) else $error("power-down byte malformed");

  property p_high_first;
    @(posedge i_core_clk) disable iff (i_rst)
    (s_q.state == ST_TX && s_q.byte_idx == 2'h0 && !pd_flag)
      |-> (s_q.cur_byte == s_q.snap[15:8]);
  endproperty
  a_high_first: assert property (p_high_first) else $error("high byte not first");

  property p_store;
    @(posedge i_core_clk) disable iff (i_rst)
    pop |=> (s_q.chan[$past(head.ch)] == $past(head.word));
  endproperty
  a_store: assert property (p_store) else $error("channel word not stored");

endmodule : dir_slave

// >>> dir_master_model.sv
// Bus master model for the readback slave: drives serial clock and open-drain data.
// Assumes pull-ups on both lines; a released data line reads high.
`timescale 1ns/100ps
module dir_master_model (
  output logic      o_scl,
  output logic      o_sda_rel,
  input  wire logic i_sda
);
  initial begin
    o_scl     = 1'b1;
    o_sda_rel = 1'b1;
  end

  // 320 ns slot, long low phase covers the slave's synchroniser delay
  task automatic bit_slot(input logic b, output logic s);
    #80 o_sda_rel = b;
    #160 o_scl = 1'b1;
    #80 s = i_sda;
    o_scl = 1'b0;
  endtask : bit_slot

  task automatic start_cond();
    #240 o_sda_rel = 1'b1;
    #40 o_scl = 1'b1;
    #160 o_sda_rel = 1'b0;
    #160 o_scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #240 o_sda_rel = 1'b0;
    #40 o_scl = 1'b1;
    #160 o_sda_rel = 1'b1;
    #160;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack_lvl);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], s);
    end
    bit_slot(1'b1, ack_lvl);
  endtask : send_byte

  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(nack, s);
  endtask : recv_byte
endmodule : dir_master_model

// >>> testbench.sv
// Self-checking bench for the readback slave with a bus master model.
// Assumes the slave's package is compiled first.
`timescale 1ns/100ps
module testbench;
  import dir_pkg::*;
  logic                        i_core_clk, i_rst, i_wr_valid, o_wr_ready, o_busy;
  logic                        scl, sda_rel, sda_wire, sda_out, sda_oe_n, pin_hi, pin_lo, a;
  dir_wr_s                     wr_data;
  logic [7:0]                  ctrl;
  logic [NUM_CH-1:0][CH_W-1:0] chan;
  logic [CH_W-1:0]             words [NUM_CH] = '{18'h0C3A5, 18'h21234, 18'h3FEDC, 18'h18001};
  int                          error_cnt = 0;
  int                          total_checks = 0;

`define chk(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); end end

  assign sda_wire = sda_rel & (sda_oe_n | sda_out);

  dir_slave dut_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_wire),
    .i_addr_pin_hi(pin_hi), .i_addr_pin_lo(pin_lo), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .i_wr_valid(i_wr_valid), .i_wr_data(wr_data),
    .o_wr_ready(o_wr_ready), .o_ctrl_byte(ctrl), .o_busy(o_busy), .o_chan_regs(chan)
  );
  dir_master_model mst_u (.o_scl(scl), .o_sda_rel(sda_rel), .i_sda(sda_wire));

  always #20 i_core_clk = ~i_core_clk;

  function automatic logic [7:0] addr_b(input logic rw);
    return {ADDR_FIXED, pin_hi, pin_lo, rw};
  endfunction : addr_b

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 200) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask : wait_idle

  // Valid stays up; the caller lowers it after the last word
  task automatic push(input logic [1:0] ch, input logic [CH_W-1:0] w);
    wr_data    = '{ch: ch, word: w};
    i_wr_valid = 1'b1;
    @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : push

  task automatic read_chk(input logic [1:0] ch, input logic pd);
    logic [7:0] d;
    logic [7:0] c;
    c = {2'b10, 3'b000, ch, pd};
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0), a);
    `chk("write address ack", 1'b0, a)
    mst_u.send_byte(c, a);
    `chk("control ack", 1'b0, a)
    `chk("control byte", c, ctrl)
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b1), a);
    `chk("read address ack", 1'b0, a)
    if (pd) begin
      mst_u.recv_byte(1'b0, d);
      `chk("power-down byte", {words[ch][17:16], PD_FILL}, d)
    end
    mst_u.recv_byte(1'b0, d);
    `chk("high byte", words[ch][15:8], d)
    mst_u.recv_byte(1'b1, d);
    `chk("low byte", words[ch][7:0], d)
    mst_u.stop_cond();
    wait_idle();
  endtask : read_chk

  initial begin
    i_core_clk = 1'b0;
    i_rst      = 1'b1;
    i_wr_valid = 1'b0;
    wr_data    = '0;
    pin_hi     = 1'b1;
    pin_lo     = 1'b0;
    repeat (12) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    `chk("reset busy", 1'b0, o_busy)
    `chk("reset ready", 1'b1, o_wr_ready)
    `chk("reset control", CTRL_RESET, ctrl)
    `chk("reset data oe", 1'b1, sda_oe_n)
    `chk("reset channels", (NUM_CH*CH_W)'(0), chan)
    // Fill the buffer while a frame holds the slave busy
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0), a);
    `chk("busy in frame", 1'b1, o_busy)
    push(2'h0, words[0]);
    push(2'h1, words[1]);
    i_wr_valid = 1'b0;
    `chk("ready when full", 1'b0, o_wr_ready)
    `chk("channel held while busy", CH_RESET, chan[0])
    mst_u.stop_cond();
    wait_idle();
    repeat (8) @(negedge i_core_clk);
    push(2'h2, words[2]);
    push(2'h3, words[3]);
    i_wr_valid = 1'b0;
    repeat (8) @(negedge i_core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      `chk("channel store", words[c], chan[c])
    end
    for (int c = 0; c < NUM_CH; c++) begin
      read_chk(c[1:0], 1'b0);
      read_chk(c[1:0], 1'b1);
    end
    // Wrong fixed bits, then wrong address pin: no acknowledge
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0) ^ 8'h40, a);
    `chk("foreign address nack", 1'b1, a)
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0) ^ 8'h04, a);
    `chk("pin mismatch nack", 1'b1, a)
    // Strap change moves the address
    pin_lo = 1'b1;
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0) ^ 8'h02, a);
    `chk("old strap nack", 1'b1, a)
    mst_u.start_cond();
    mst_u.send_byte(addr_b(1'b0), a);
    `chk("restart write address ack", 1'b0, a)
    mst_u.stop_cond();
    wait_idle();
    complete_run();
  end
endmodule : testbench
